// ---- shared/rif_map.svh ----
`ifndef RIF_MAP_SVH
`define RIF_MAP_SVH

// Register offsets on the internal register port
`define RIF_SOFT_RESET_OFS   8'h18
`define RIF_TOP_OFS          8'h19
`define RIF_RESET_EVT_OFS    8'h1A
`define RIF_BUCK_OFS         8'h1B
`define RIF_LINREG_OFS       8'h1C
`define RIF_LIVE_OFS         8'h1D

// Reset values
`define RIF_RESET_VALUE      8'h00

// Writable (write-one-to-clear) bits of each flag register
`define RIF_TOP_W1C_MASK     8'h9F
`define RIF_REG_W1C_MASK     8'h77
`define RIF_RESET_EVT_MASK   8'h01

// Field positions in the top flag register
`define RIF_TOP_PG_BIT       7
`define RIF_TOP_LINREG_BIT   6
`define RIF_TOP_BUCK_BIT     5
`define RIF_TOP_SYNC_BIT     4
`define RIF_TOP_TSD_BIT      3
`define RIF_TOP_WARN_BIT     2
`define RIF_TOP_OVP_BIT      1
`define RIF_TOP_MEAS_BIT     0

// Field positions in the buck and linear regulator flag registers
`define RIF_A_PG_BIT         2
`define RIF_A_SC_BIT         1
`define RIF_A_ILIM_BIT       0
`define RIF_B_PG_BIT         6
`define RIF_B_SC_BIT         5
`define RIF_B_ILIM_BIT       4

// Field positions in the reset and live status registers
`define RIF_SOFT_RESET_BIT   0
`define RIF_RESET_EVT_BIT    0
`define RIF_LIVE_PG_BIT      7
`define RIF_LIVE_SYNC_BIT    4
`define RIF_LIVE_TSD_BIT     3
`define RIF_LIVE_WARN_BIT    2
`define RIF_LIVE_OVP_BIT     1

// Timing
`define RIF_CLK_PERIOD_NS    20
`define RIF_SC_TIME_NS       1000000
`define RIF_SC_CYCLES        ((`RIF_SC_TIME_NS + `RIF_CLK_PERIOD_NS - 1) / `RIF_CLK_PERIOD_NS)
`define RIF_SC_CNT_W         17

`endif

// ---- shared/rif_pkg.sv ----
package rif_pkg;

    typedef enum logic [1:0] {
        RIF_SEQ_RUN   = 2'b00,
        RIF_SEQ_HOLD  = 2'b01,
        RIF_SEQ_START = 2'b10
    } rif_seq_t;

    typedef logic [2:0] rif_reg_evt_t;

endpackage : rif_pkg

// ---- rtl/rif_short_timer.sv ----
`timescale 1ns/100ps
`include "rif_map.svh"

module rif_short_timer #(
    parameter int SC_CYCLES = `RIF_SC_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic clear,
    input  wire logic below,
    output logic      expired
);

    localparam logic [`RIF_SC_CNT_W-1:0] LIMIT = `RIF_SC_CNT_W'(SC_CYCLES);

    logic [`RIF_SC_CNT_W-1:0] cnt;

    // Any sample above threshold restarts the window
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
        end else if (clear || !below) begin
            cnt <= '0;
        end else if (cnt != LIMIT) begin
            cnt <= cnt + `RIF_SC_CNT_W'(1);
        end
    end

    // Fires only once the low level has outlasted the full window
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            expired <= 1'b0;
        end else begin
            expired <= !clear && below && (cnt == LIMIT);
        end
    end

endmodule : rif_short_timer

// ---- rtl/rif_top.sv ----
`timescale 1ns/100ps
`include "rif_map.svh"

// Overview of operation
// - Power-good output falling from active to inactive latches top bit 7.
// - Each latched flag clears when the host writes one to it; a reset event also clears all but the reset flag.
// - Linear regulator summary bit reads set while its flag register is nonzero.
// - Buck summary bit reads set while the buck flag register is nonzero.
// - External clock appearing or disappearing latches the clock flag.
// - Thermal shutdown latches its flag, drops regulators and general outputs.
// - No regulator is enabled while the latched shutdown flag is set.
// - A live thermal shutdown status bit sits beside the latched flag.
// - Thermal warning latches its flag and has a live status bit.
// - Overvoltage latches its flag, drops regulators and outputs, live bit too.
// - A new load current result latches the measurement-done flag, bit 0.
// - Supply undervoltage or software reset latches the reset flag at 0x1A.
// - A reset event drops regulators, defaults registers, then starts up again.
// - Buck power-good events latch bit 2 for buck A, bit 6 for buck B.
// - Buck short flag latches after output stays low more than 1 ms.
// - Buck current-limit flag latches whenever its limiter has been active.
// - Reset flag register reads zero after reset, reserved bits included.
// - Linear regulators keep their own power-good, short and limit flags.
// - Software reset request bit clears itself after triggering the reset.
module rif_top #(
    parameter int SC_CYCLES = `RIF_SC_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    output logic      [7:0] reg_rd_data,
    input  wire logic       power_good_output,
    input  wire logic       ext_clk_present,
    input  wire logic       thermal_shutdown_in,
    input  wire logic       thermal_warning_in,
    input  wire logic       input_overvoltage_in,
    input  wire logic       meas_done,
    input  wire logic       analog_supply_uv,
    input  wire logic [3:0] pg_invalid,
    input  wire logic [3:0] below_sc,
    input  wire logic [3:0] ilim_active,
    input  wire logic [3:0] reg_enable_req,
    input  wire logic       general_output_a_req,
    input  wire logic       general_output_b_req,
    output logic      [3:0] reg_enable,
    output logic            general_output_a,
    output logic            general_output_b,
    output logic            thermal_shutdown_live,
    output logic            thermal_warning_live,
    output logic            input_overvoltage_live,
    output logic            serial_reset,
    output logic            mem_reload,
    output logic            startup_start
);

    rif_pkg::rif_seq_t state;
    rif_pkg::rif_seq_t next_state;

    logic [7:0] top_flags;
    logic [7:0] buck_event_flags;
    logic [7:0] linreg_event_flags;
    logic [7:0] reset_event_flags;
    logic       soft_reset_request;
    logic [7:0] next_top;
    logic [7:0] next_buck;
    logic [7:0] next_linreg;
    logic [7:0] next_reset_evt;
    logic [7:0] next_rd_data;
    logic [7:0] top_set;
    logic [7:0] buck_set;
    logic [7:0] linreg_set;
    logic       pg_prev;
    logic       clk_prev;
    logic [3:0] pgi_prev;
    logic       run;
    logic       hold;
    logic       wr_ok;
    logic       reset_evt;
    logic       kill;
    logic       buck_summary_flag;
    logic       linreg_summary_flag;
    logic       power_good_drop;
    logic       sync_change;
    logic [3:0] sc_expired;

    rif_pkg::rif_reg_evt_t reg_evt [4];

    assign run       = (state == rif_pkg::RIF_SEQ_RUN);
    assign hold      = (state == rif_pkg::RIF_SEQ_HOLD);
    assign wr_ok     = reg_wr && run;
    assign reset_evt = run && (analog_supply_uv || soft_reset_request);

    // Sequencer for undervoltage and software reset
    always_comb begin
        next_state = state;
        case (state)
            rif_pkg::RIF_SEQ_RUN: begin
                if (reset_evt) begin
                    next_state = rif_pkg::RIF_SEQ_HOLD;
                end
            end
            rif_pkg::RIF_SEQ_HOLD: begin
                // Stay down as long as the supply is still low
                if (!analog_supply_uv) begin
                    next_state = rif_pkg::RIF_SEQ_START;
                end
            end
            rif_pkg::RIF_SEQ_START: begin
                next_state = rif_pkg::RIF_SEQ_RUN;
            end
            default: begin
                next_state = rif_pkg::RIF_SEQ_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= rif_pkg::RIF_SEQ_RUN;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_reset  <= 1'b0;
            mem_reload    <= 1'b0;
            startup_start <= 1'b0;
        end else begin
            serial_reset  <= run && soft_reset_request;
            mem_reload    <= run && soft_reset_request;
            startup_start <= (state == rif_pkg::RIF_SEQ_START);
        end
    end

    // Request bit lives exactly one cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            soft_reset_request <= 1'b0;
        end else if (soft_reset_request || !run) begin
            soft_reset_request <= 1'b0;
        end else if (wr_ok && reg_addr == `RIF_SOFT_RESET_OFS) begin
            soft_reset_request <= reg_wdata[`RIF_SOFT_RESET_BIT];
        end
    end

    // Edge history for event detection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pg_prev  <= 1'b0;
            clk_prev <= 1'b0;
            pgi_prev <= 4'h0;
        end else begin
            pg_prev  <= power_good_output;
            clk_prev <= ext_clk_present;
            pgi_prev <= pg_invalid;
        end
    end

    assign power_good_drop = pg_prev && !power_good_output;
    assign sync_change     = clk_prev != ext_clk_present;

    // Index 0,1 are bucks A,B; index 2,3 are linear regulators A,B
    for (genvar i = 0; i < 4; i++) begin : g_reg
        rif_short_timer #(
            .SC_CYCLES (SC_CYCLES)
        ) u_sc (
            .clk     (clk),
            .rst_n   (rst_n),
            .clear   (!run),
            .below   (below_sc[i]),
            .expired (sc_expired[i])
        );

        // Valid to invalid is the power-good event
        assign reg_evt[i] = {pg_invalid[i] && !pgi_prev[i], sc_expired[i],
                             ilim_active[i]};
    end

    assign buck_set   = {1'b0, reg_evt[1], 1'b0, reg_evt[0]};
    assign linreg_set = {1'b0, reg_evt[3], 1'b0, reg_evt[2]};
    assign top_set    = {power_good_drop, 2'b00, sync_change, thermal_shutdown_in,
                         thermal_warning_in, input_overvoltage_in, meas_done};

    // Set wins over a clear in the same cycle so no event is lost
    always_comb begin
        next_top       = top_flags;
        next_buck      = buck_event_flags;
        next_linreg    = linreg_event_flags;
        next_reset_evt = reset_event_flags;
        if (wr_ok && reg_addr == `RIF_TOP_OFS) begin
            next_top = top_flags & ~(reg_wdata & `RIF_TOP_W1C_MASK);
        end
        if (wr_ok && reg_addr == `RIF_BUCK_OFS) begin
            next_buck = buck_event_flags & ~(reg_wdata & `RIF_REG_W1C_MASK);
        end
        if (wr_ok && reg_addr == `RIF_LINREG_OFS) begin
            next_linreg = linreg_event_flags & ~(reg_wdata & `RIF_REG_W1C_MASK);
        end
        if (wr_ok && reg_addr == `RIF_RESET_EVT_OFS) begin
            next_reset_evt = reset_event_flags & ~(reg_wdata & `RIF_RESET_EVT_MASK);
        end
        next_top       = (next_top | top_set) & `RIF_TOP_W1C_MASK;
        next_buck      = (next_buck | buck_set) & `RIF_REG_W1C_MASK;
        next_linreg    = (next_linreg | linreg_set) & `RIF_REG_W1C_MASK;
        next_reset_evt = next_reset_evt & `RIF_RESET_EVT_MASK;
        if (reset_evt) begin
            next_reset_evt[`RIF_RESET_EVT_BIT] = 1'b1;
        end
    end

    // Reset event returns every other flag to default
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            top_flags          <= `RIF_RESET_VALUE;
            buck_event_flags   <= `RIF_RESET_VALUE;
            linreg_event_flags <= `RIF_RESET_VALUE;
        end else if (hold) begin
            top_flags          <= `RIF_RESET_VALUE;
            buck_event_flags   <= `RIF_RESET_VALUE;
            linreg_event_flags <= `RIF_RESET_VALUE;
        end else begin
            top_flags          <= next_top;
            buck_event_flags   <= next_buck;
            linreg_event_flags <= next_linreg;
        end
    end

    // The reset flag must outlive the reset it reports
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_event_flags <= `RIF_RESET_VALUE;
        end else begin
            reset_event_flags <= next_reset_evt;
        end
    end

    assign buck_summary_flag   = |buck_event_flags;
    assign linreg_summary_flag = |linreg_event_flags;

    // Live status follows the inputs with one register of delay
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            thermal_shutdown_live  <= 1'b0;
            thermal_warning_live   <= 1'b0;
            input_overvoltage_live <= 1'b0;
        end else begin
            thermal_shutdown_live  <= thermal_shutdown_in;
            thermal_warning_live   <= thermal_warning_in;
            input_overvoltage_live <= input_overvoltage_in;
        end
    end

    // Latched shutdown keeps everything off until software clears it
    assign kill = top_flags[`RIF_TOP_TSD_BIT] || top_flags[`RIF_TOP_OVP_BIT]
               || thermal_shutdown_in || input_overvoltage_in || !run;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_enable       <= 4'h0;
            general_output_a <= 1'b0;
            general_output_b <= 1'b0;
        end else if (kill) begin
            reg_enable       <= 4'h0;
            general_output_a <= 1'b0;
            general_output_b <= 1'b0;
        end else begin
            reg_enable       <= reg_enable_req;
            general_output_a <= general_output_a_req;
            general_output_b <= general_output_b_req;
        end
    end

    // Read data is registered; unmapped addresses read zero
    always_comb begin
        next_rd_data = 8'h00;
        if (reg_addr == `RIF_TOP_OFS) begin
            next_rd_data = top_flags;
            next_rd_data[`RIF_TOP_LINREG_BIT] = linreg_summary_flag;
            next_rd_data[`RIF_TOP_BUCK_BIT]   = buck_summary_flag;
        end else if (reg_addr == `RIF_RESET_EVT_OFS) begin
            next_rd_data = reset_event_flags;
        end else if (reg_addr == `RIF_BUCK_OFS) begin
            next_rd_data = buck_event_flags;
        end else if (reg_addr == `RIF_LINREG_OFS) begin
            next_rd_data = linreg_event_flags;
        end else if (reg_addr == `RIF_SOFT_RESET_OFS) begin
            next_rd_data[`RIF_SOFT_RESET_BIT] = soft_reset_request;
        end else if (reg_addr == `RIF_LIVE_OFS) begin
            next_rd_data[`RIF_LIVE_PG_BIT]   = power_good_output;
            next_rd_data[`RIF_LIVE_SYNC_BIT] = !ext_clk_present;
            next_rd_data[`RIF_LIVE_TSD_BIT]  = thermal_shutdown_live;
            next_rd_data[`RIF_LIVE_WARN_BIT] = thermal_warning_live;
            next_rd_data[`RIF_LIVE_OVP_BIT]  = input_overvoltage_live;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rd_data <= 8'h00;
        end else begin
            reg_rd_data <= next_rd_data;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_reset_evt;
        run && (analog_supply_uv || soft_reset_request);
    endsequence

    sequence s_reset_down;
        hold ##1 (reg_enable == 4'h0 && !general_output_a && !general_output_b);
    endsequence

    pg_drop_latch_a : assert property (
        (run && pg_prev && !power_good_output) |=> top_flags[`RIF_TOP_PG_BIT])
        else $error("power-good drop not latched");
    w1c_clear_a : assert property (
        (wr_ok && reg_addr == `RIF_TOP_OFS && reg_wdata[`RIF_TOP_MEAS_BIT] && !meas_done)
        |=> !top_flags[`RIF_TOP_MEAS_BIT])
        else $error("measurement flag not cleared by write of one");
    zero_write_hold_a : assert property (
        (run && top_flags[`RIF_TOP_SYNC_BIT] && !(wr_ok && reg_addr == `RIF_TOP_OFS
         && reg_wdata[`RIF_TOP_SYNC_BIT]) && !reset_evt) |=> top_flags[`RIF_TOP_SYNC_BIT])
        else $error("clock flag lost without a write of one");
    linreg_summary_a : assert property (
        (reg_addr == `RIF_TOP_OFS)
        |=> reg_rd_data[`RIF_TOP_LINREG_BIT] == $past(|linreg_event_flags))
        else $error("linear regulator summary mismatch");
    buck_summary_a : assert property (
        (reg_addr == `RIF_TOP_OFS) |=> reg_rd_data[`RIF_TOP_BUCK_BIT] == $past(|buck_event_flags))
        else $error("buck summary mismatch");
    sync_change_a : assert property (
        (run && $changed(ext_clk_present)) |=> top_flags[`RIF_TOP_SYNC_BIT])
        else $error("clock change not latched");
    tsd_refuse_a : assert property (
        top_flags[`RIF_TOP_TSD_BIT] |=> (reg_enable == 4'h0))
        else $error("regulator enabled under latched shutdown");
    ovp_outputs_low_a : assert property (
        input_overvoltage_in |=> (!general_output_a && !general_output_b && input_overvoltage_live))
        else $error("outputs not driven low on overvoltage");
    meas_latch_a : assert property (
        (run && meas_done) |=> top_flags[`RIF_TOP_MEAS_BIT])
        else $error("measurement done not latched");
    reset_flag_a : assert property (
        s_reset_evt |=> reset_event_flags[`RIF_RESET_EVT_BIT])
        else $error("reset event not latched");
    reset_sequence_a : assert property (
        s_reset_evt |=> s_reset_down)
        else $error("reset event did not shut regulators down");
    soft_selfclear_a : assert property (
        soft_reset_request |=> (!soft_reset_request && serial_reset && mem_reload))
        else $error("software reset bit did not self clear");
    buck_short_a : assert property (
        (run && sc_expired[0] && !hold) |=> buck_event_flags[`RIF_A_SC_BIT])
        else $error("buck short flag not latched");

endmodule : rif_top

// ---- dv/rif_host_model.sv ----
`timescale 1ns/100ps
`include "rif_map.svh"

// Host on the register port: drives just after an edge and holds until the next one
module rif_host_model (
    input  wire logic       clk,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    input  wire logic [7:0] reg_rd_data
);
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
    end

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        // Idle data shows the inverse, so a stale value cannot pass for a write
        reg_wdata <= ~d;
    endtask : wr_reg

    // Read data is registered, so the address stands over several edges
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        repeat (3) @(posedge clk);
        #1 d = reg_rd_data;
    endtask : rd_reg

    // Top register first, then the flagged sub-register, cleared by writing its ones back
    task automatic service();
        logic [7:0] top;
        logic [7:0] sub;
        rd_reg(`RIF_TOP_OFS, top);
        if (top[`RIF_TOP_BUCK_BIT] === 1'b1) begin
            rd_reg(`RIF_BUCK_OFS, sub);
            wr_reg(`RIF_BUCK_OFS, sub);
        end
        if (top[`RIF_TOP_LINREG_BIT] === 1'b1) begin
            rd_reg(`RIF_LINREG_OFS, sub);
            wr_reg(`RIF_LINREG_OFS, sub);
        end
    endtask : service
endmodule : rif_host_model

// ---- dv/tb_regulator_interrupt_flags.sv ----
`timescale 1ns/100ps
`include "rif_map.svh"

module tb_regulator_interrupt_flags;
    localparam int SC = 8;
    logic       clk;
    logic       rst_n;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic [7:0] reg_rd_data;
    logic       power_good_output;
    logic       ext_clk_present;
    logic [2:0] cond;
    logic       meas_done;
    logic       analog_supply_uv;
    logic [3:0] pg_invalid;
    logic [3:0] below_sc;
    logic [3:0] ilim_active;
    logic [3:0] reg_enable_req;
    logic [3:0] reg_enable;
    logic [1:0] gen_out;
    logic [1:0] gen_out_req;
    logic [5:0] on_mask;
    logic [2:0] live;
    logic       serial_reset;
    logic       mem_reload;
    logic       startup_start;
    logic [2:0] seen_pulses = 3'b000;
    logic [7:0] rd;
    logic [7:0] a;
    logic [7:0] sum;
    int         fails;
    int         samples_checked;

    rif_top #(.SC_CYCLES(SC)) i_dut (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd_data(reg_rd_data), .power_good_output(power_good_output),
        .ext_clk_present(ext_clk_present), .thermal_shutdown_in(cond[2]),
        .thermal_warning_in(cond[1]), .input_overvoltage_in(cond[0]), .meas_done(meas_done),
        .analog_supply_uv(analog_supply_uv), .pg_invalid(pg_invalid), .below_sc(below_sc),
        .ilim_active(ilim_active), .reg_enable_req(reg_enable_req),
        .general_output_a_req(gen_out_req[1]), .general_output_b_req(gen_out_req[0]),
        .reg_enable(reg_enable), .general_output_a(gen_out[1]),
        .general_output_b(gen_out[0]), .thermal_shutdown_live(live[2]),
        .thermal_warning_live(live[1]), .input_overvoltage_live(live[0]),
        .serial_reset(serial_reset), .mem_reload(mem_reload), .startup_start(startup_start)
    );

    rif_host_model i_host (
        .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd_data(reg_rd_data)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // One-cycle pulses are caught here so the reset test can look later
    always @(posedge clk) begin
        seen_pulses <= seen_pulses | {serial_reset === 1'b1, mem_reload === 1'b1,
                                      startup_start === 1'b1};
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic chk_reg(input logic [7:0] ofs, input logic [7:0] exp);
        i_host.rd_reg(ofs, rd);
        check({8'h00, rd}, {8'h00, exp});
    endtask : chk_reg

    task automatic final_report();
        $display("compares %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        final_report();
    end

    initial begin
        fails = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        power_good_output = 1'b0;
        ext_clk_present = 1'b0;
        cond = 3'b000;
        meas_done = 1'b0;
        analog_supply_uv = 1'b0;
        pg_invalid = 4'h0;
        below_sc = 4'h0;
        ilim_active = 4'h0;
        reg_enable_req = 4'hF;
        gen_out_req = 2'b11;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        chk_reg(`RIF_RESET_EVT_OFS, 8'h00);
        chk_reg(`RIF_TOP_OFS, 8'h00);
        chk_reg(`RIF_BUCK_OFS, 8'h00);
        chk_reg(`RIF_LINREG_OFS, 8'h00);
        chk_reg(8'h3F, 8'h00);
        $display("test reset values done");

        @(posedge clk) power_good_output <= 1'b1;
        chk_reg(`RIF_TOP_OFS, 8'h00);
        @(posedge clk) power_good_output <= 1'b0;
        chk_reg(`RIF_TOP_OFS, 8'h80);
        i_host.wr_reg(`RIF_TOP_OFS, 8'h00);
        chk_reg(`RIF_TOP_OFS, 8'h80);
        i_host.wr_reg(`RIF_TOP_OFS, 8'h7F);
        chk_reg(`RIF_TOP_OFS, 8'h80);
        i_host.wr_reg(`RIF_TOP_OFS, 8'h80);
        chk_reg(`RIF_TOP_OFS, 8'h00);
        for (int v = 1; v >= 0; v--) begin
            @(posedge clk) ext_clk_present <= v[0];
            chk_reg(`RIF_TOP_OFS, 8'h10);
            i_host.wr_reg(`RIF_TOP_OFS, 8'h10);
        end
        chk_reg(`RIF_TOP_OFS, 8'h00);
        @(posedge clk) meas_done <= 1'b1;
        @(posedge clk) meas_done <= 1'b0;
        chk_reg(`RIF_TOP_OFS, 8'h01);
        i_host.wr_reg(`RIF_TOP_OFS, 8'h01);
        $display("test top events done");

        // Shutdown, warning, overvoltage; only warning leaves the outputs alone
        for (int k = 0; k < 3; k++) begin
            on_mask = (k == 1) ? 6'h3F : 6'h00;
            @(posedge clk) cond <= 3'b100 >> k;
            repeat (4) @(posedge clk);
            #1 check({7'h0, live, gen_out, reg_enable}, {7'h0, 3'b100 >> k, on_mask});
            // External clock is absent here, so its live bit reads invalid
            chk_reg(`RIF_LIVE_OFS, 8'h10 | (8'h08 >> k));
            @(posedge clk) cond <= 3'b000;
            repeat (4) @(posedge clk);
            #1 check({7'h0, live, gen_out, reg_enable}, {7'h0, 3'b000, on_mask});
            chk_reg(`RIF_TOP_OFS, 8'h08 >> k);
            i_host.wr_reg(`RIF_TOP_OFS, 8'h08 >> k);
            repeat (4) @(posedge clk);
            #1 check({10'h0, gen_out, reg_enable}, 16'h003F);
        end
        @(posedge clk) gen_out_req <= 2'b01;
        repeat (2) @(posedge clk);
        #1 check({14'h0, gen_out}, 16'h0001);
        $display("test thermal and overvoltage done");

        for (int i = 0; i < 4; i++) begin
            a = (i < 2) ? `RIF_BUCK_OFS : `RIF_LINREG_OFS;
            sum = (i < 2) ? 8'h20 : 8'h40;
            // A dip shorter than the window must not latch
            @(posedge clk) below_sc[i] <= 1'b1;
            repeat (SC - 3) @(posedge clk);
            below_sc[i] <= 1'b0;
            chk_reg(a, 8'h00);
            @(posedge clk) {pg_invalid[i], below_sc[i], ilim_active[i]} <= 3'b111;
            repeat (SC + 6) @(posedge clk);
            {pg_invalid[i], below_sc[i], ilim_active[i]} <= 3'b000;
            chk_reg(a, 8'h07 << ((i % 2) * 4));
            chk_reg(`RIF_TOP_OFS, sum);
            i_host.wr_reg(`RIF_TOP_OFS, sum);
            chk_reg(`RIF_TOP_OFS, sum);
            i_host.service();
            chk_reg(a, 8'h00);
            chk_reg(`RIF_TOP_OFS, 8'h00);
        end
        $display("test regulator flags done");

        @(posedge clk) meas_done <= 1'b1;
        @(posedge clk) meas_done <= 1'b0;
        i_host.wr_reg(`RIF_SOFT_RESET_OFS, 8'h01);
        repeat (10) @(posedge clk);
        chk_reg(`RIF_RESET_EVT_OFS, 8'h01);
        chk_reg(`RIF_TOP_OFS, 8'h00);
        chk_reg(`RIF_SOFT_RESET_OFS, 8'h00);
        check({13'h0, seen_pulses}, 16'h0007);
        i_host.wr_reg(`RIF_RESET_EVT_OFS, 8'h00);
        chk_reg(`RIF_RESET_EVT_OFS, 8'h01);
        i_host.wr_reg(`RIF_RESET_EVT_OFS, 8'h01);
        chk_reg(`RIF_RESET_EVT_OFS, 8'h00);
        @(posedge clk) analog_supply_uv <= 1'b1;
        repeat (4) @(posedge clk);
        #1 check({12'h0, reg_enable}, 16'h0000);
        @(posedge clk) analog_supply_uv <= 1'b0;
        repeat (10) @(posedge clk);
        chk_reg(`RIF_RESET_EVT_OFS, 8'h01);
        $display("test reset events done");
        final_report();
    end
endmodule : tb_regulator_interrupt_flags
